// ==== rtl/tpdi_regs.vh ====
`ifndef TPDI_REGS_VH
`define TPDI_REGS_VH

// Register byte offsets on the APB port.
`define TPDI_CTRL_OFF     12'h000
`define TPDI_STATUS_OFF   12'h004
`define TPDI_PIXSEL_OFF   12'h008
`define TPDI_PIXDATA_OFF  12'h00c

// Panel geometry and pixel layout.
`define TPDI_COLS         240
`define TPDI_ROWS         320
`define TPDI_CBITS        6
`define TPDI_PBITS        18

// Status field positions.
`define TPDI_ST_FETCH     9
`define TPDI_ST_DRIVE     10
`define TPDI_ST_COMMON    11
`define TPDI_ST_POLPOS    12
`define TPDI_ST_GAMEXT    13

// Control and bus constants.
`define TPDI_ADDR_W       12
`define TPDI_DATA_W       32
`define TPDI_ZERO32       32'h0000_0000

`endif

// ==== rtl/tpdi_sync_edge.v ====
`include "tpdi_regs.vh"

// Two-stage synchroniser with edge detection on the stage behind it.
module tpdi_sync_edge #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] lvl,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end
        else if (ce)
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl  = s2_q;
    assign rise = s2_q & ~s3_q & {W{ce}};
    assign fall = ~s2_q & s3_q & {W{ce}};
endmodule // tpdi_sync_edge

// ==== rtl/tpdi_gate_shift.v ====
`include "tpdi_regs.vh"

// Row scan shift register: loads on the clock rise, shows on the fall.
module tpdi_gate_shift #(
    parameter ROWS = `TPDI_ROWS
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            ce,
    input  wire            gclk_rise,
    input  wire            gclk_fall,
    input  wire            start,
    input  wire            oe_n,
    output wire [ROWS-1:0] gate_out
);
    reg [ROWS-1:0] stage_q;
    reg [ROWS-1:0] sr_q;
    reg [ROWS-1:0] out_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_q <= {ROWS{1'b0}};
            sr_q    <= {ROWS{1'b0}};
            out_q   <= {ROWS{1'b0}};
        end
        else if (ce)
        begin
            if (gclk_rise)
            begin
                stage_q <= {sr_q[ROWS-2:0], start};
            end
            if (gclk_fall)
            begin
                sr_q <= stage_q;
            end
            out_q <= oe_n ? {ROWS{1'b0}} : sr_q;
        end
    end

    assign gate_out = out_q;
endmodule // tpdi_gate_shift

// ==== rtl/tpdi_panel.v ====
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "tpdi_regs.vh"

module tpdi_panel #(
    parameter COLS = `TPDI_COLS,
    parameter ROWS = `TPDI_ROWS
) (
    input  wire                        pclk,
    input  wire                        presetn,
    input  wire                        ce,
    input  wire                        psel,
    input  wire                        penable,
    input  wire                        pwrite,
    input  wire [`TPDI_ADDR_W-1:0]     paddr,
    input  wire [`TPDI_DATA_W-1:0]     pwdata,
    output wire [`TPDI_DATA_W-1:0]     prdata,
    output wire                        pready,
    output wire                        pslverr,
    input  wire                        column_shift_clock,
    input  wire                        line_latch_strobe,
    input  wire                        line_start_pulse,
    input  wire                        polarity_select,
    input  wire                        data_invert,
    input  wire                        amp_drive_enable,
    input  wire                        gate_shift_clock,
    input  wire                        gate_output_enable_n,
    input  wire                        frame_start_pulse,
    input  wire                        curve_source_select,
    input  wire [`TPDI_CBITS-1:0]      red_data,
    input  wire [`TPDI_CBITS-1:0]      green_data,
    input  wire [`TPDI_CBITS-1:0]      blue_data,
    output wire [COLS*`TPDI_PBITS-1:0] column_level,
    output wire                        column_drive_en,
    output wire                        common_drive_out,
    output wire                        gamma_positive,
    output wire                        gamma_external,
    output wire [ROWS-1:0]             gate_out
);
    localparam PW = `TPDI_PBITS;
    localparam CB = `TPDI_CBITS;
    localparam CW = $clog2(COLS + 1);
    localparam SW = 8 + 3 * CB;
    localparam [CW-1:0] COLS_C = COLS[CW-1:0];

    wire [SW-1:0] sync_lvl;
    wire [SW-1:0] sync_rise;
    wire [SW-1:0] sync_fall;

    // Every panel control and pixel pin passes a two-stage synchroniser before use; the APB pins and ce do not.
    tpdi_sync_edge #(
        .W (SW)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({curve_source_select, amp_drive_enable, data_invert, polarity_select,
                   line_start_pulse, line_latch_strobe, column_shift_clock, gate_shift_clock,
                   red_data, green_data, blue_data}),
        .lvl     (sync_lvl),
        .rise    (sync_rise),
        .fall    (sync_fall)
    );

    wire          gclk_rise  = sync_rise[3 * CB];
    wire          gclk_fall  = sync_fall[3 * CB];
    wire          col_rise   = sync_rise[3 * CB + 1];
    wire          latch_lvl  = sync_lvl[3 * CB + 2];
    wire          latch_rise = sync_rise[3 * CB + 2];
    wire          lsp_lvl    = sync_lvl[3 * CB + 3];
    wire          polar_lvl  = sync_lvl[3 * CB + 4];
    wire          flip_lvl   = sync_lvl[3 * CB + 5];
    wire          amp_rise   = sync_rise[3 * CB + 6];
    wire          curve_lvl  = sync_lvl[3 * CB + 7];
    wire [PW-1:0] pix_in     = sync_lvl[PW-1:0];

    reg  [PW-1:0] data_q;
    reg  [CW-1:0] idx_q;
    reg           fetch_q;
    reg           store_q;
    reg  [CW-1:0] slot_q;
    reg           drive_q;
    reg           common_q;
    reg           polpos_q;
    reg           gamext_q;
    reg  [CW-1:0] line_len_q;
    reg  [CW-1:0] pix_sel_q;
    reg  [`TPDI_DATA_W-1:0] rdata_q;
    reg           err_q;
    reg  [PW-1:0] shift_q [0:COLS-1];
    reg  [COLS*PW-1:0] line_q;

    // The buses carry red, green, blue, each with its low line as bit 0.
    wire          capture = col_rise & fetch_q & (idx_q < line_len_q) & (idx_q < COLS_C);
    wire          xfer    = col_rise & latch_lvl;

    // Data register and column fetch position.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_q  <= {PW{1'b0}};
            idx_q   <= {CW{1'b0}};
            fetch_q <= 1'b0;
            store_q <= 1'b0;
            slot_q  <= {CW{1'b0}};
        end
        else if (ce)
        begin
            if (col_rise)
            begin
                data_q <= flip_lvl ? ~pix_in : pix_in;
            end
            store_q <= capture;
            slot_q  <= idx_q;
            if (latch_rise)
            begin
                idx_q   <= {CW{1'b0}};
                fetch_q <= 1'b0;
            end
            else if (col_rise && lsp_lvl)
            begin
                idx_q   <= {CW{1'b0}};
                fetch_q <= 1'b1;
            end
            else if (capture)
            begin
                idx_q <= idx_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Column storage, one entry per column, cleared by the strobe edge.
    genvar gi;
    generate
        for (gi = 0; gi < COLS; gi = gi + 1)
        begin : g_col
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    shift_q[gi] <= {PW{1'b0}};
                end
                else if (ce)
                begin
                    if (latch_rise)
                    begin
                        shift_q[gi] <= {PW{1'b0}};
                    end
                    else if (store_q && slot_q == gi)
                    begin
                        shift_q[gi] <= data_q;
                    end
                end
            end

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    line_q[gi*PW +: PW] <= {PW{1'b0}};
                end
                else if (ce && xfer)
                begin
                    line_q[gi*PW +: PW] <= shift_q[gi];
                end
            end
        end
    endgenerate

    // Output stage: polarity, common drive, column switches and gamma source.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_q  <= 1'b0;
            common_q <= 1'b0;
            polpos_q <= 1'b0;
            gamext_q <= 1'b0;
        end
        else if (ce)
        begin
            if (latch_rise)
            begin
                common_q <= ~polar_lvl;
                polpos_q <= polar_lvl;
                drive_q  <= 1'b0;
            end
            else if (amp_rise)
            begin
                drive_q <= 1'b1;
            end
            gamext_q <= curve_lvl;
        end
    end

    // Frame start and gate enable take their own synchroniser.
    wire [1:0] gate_lvl;
    wire       frame_start_pulse_s    = gate_lvl[1];
    wire       gate_output_enable_n_s = gate_lvl[0];

    tpdi_sync_edge #(
        .W (2)
    ) u_sync_gate (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({frame_start_pulse, gate_output_enable_n}),
        .lvl     (gate_lvl),
        .rise    (),
        .fall    ()
    );

    tpdi_gate_shift #(
        .ROWS (ROWS)
    ) u_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .gclk_rise (gclk_rise),
        .gclk_fall (gclk_fall),
        .start     (frame_start_pulse_s),
        .oe_n      (gate_output_enable_n_s),
        .gate_out  (gate_out)
    );

    // APB slave: zero wait states, read data registered in the setup cycle.
    wire setup  = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    reg  [`TPDI_DATA_W-1:0] rd_mux;
    reg                     rd_err;

    always @*
    begin
        rd_mux = `TPDI_ZERO32;
        rd_err = 1'b0;
        if (paddr == `TPDI_CTRL_OFF)
        begin
            rd_mux[CW-1:0] = line_len_q;
        end
        else if (paddr == `TPDI_STATUS_OFF)
        begin
            rd_mux[CW-1:0]           = idx_q;
            rd_mux[`TPDI_ST_FETCH]   = fetch_q;
            rd_mux[`TPDI_ST_DRIVE]   = drive_q;
            rd_mux[`TPDI_ST_COMMON]  = common_q;
            rd_mux[`TPDI_ST_POLPOS]  = polpos_q;
            rd_mux[`TPDI_ST_GAMEXT]  = gamext_q;
        end
        else if (paddr == `TPDI_PIXSEL_OFF)
        begin
            rd_mux[CW-1:0] = pix_sel_q;
        end
        else if (paddr == `TPDI_PIXDATA_OFF)
        begin
            if (pix_sel_q < COLS_C)
            begin
                rd_mux[PW-1:0] = line_q[pix_sel_q*PW +: PW];
            end
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q    <= `TPDI_ZERO32;
            err_q      <= 1'b0;
            line_len_q <= COLS_C;
            pix_sel_q  <= {CW{1'b0}};
        end
        else if (ce)
        begin
            if (setup)
            begin
                rdata_q <= pwrite ? `TPDI_ZERO32 : rd_mux;
                err_q   <= rd_err;
            end
            if (wr_acc && paddr == `TPDI_CTRL_OFF)
            begin
                line_len_q <= pwdata[CW-1:0];
            end
            else if (wr_acc && paddr == `TPDI_PIXSEL_OFF)
            begin
                pix_sel_q <= pwdata[CW-1:0];
            end
        end
    end

    assign prdata           = rdata_q;
    assign pready           = 1'b1;
    assign pslverr          = err_q & psel & penable;
    assign column_level     = line_q;
    assign column_drive_en  = drive_q;
    assign common_drive_out = common_q;
    assign gamma_positive   = polpos_q;
    assign gamma_external   = gamext_q;
endmodule // tpdi_panel

// ==== tb/tpdi_panel_chk.sv ====
module tpdi_panel_chk #(
    parameter COLS = 240,
    parameter ROWS = 320
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              line_latch_strobe,
    input wire logic              polarity_select,
    input wire logic              amp_drive_enable,
    input wire logic              gate_output_enable_n,
    input wire logic              curve_source_select,
    input wire logic [COLS*18-1:0] column_level,
    input wire logic              column_drive_en,
    input wire logic              common_drive_out,
    input wire logic              gamma_positive,
    input wire logic              gamma_external,
    input wire logic [ROWS-1:0]   gate_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_drive_off: assert property ($rose(line_latch_strobe) |-> ##[1:6] !column_drive_en)
        else $error("column drive still on after strobe");
    a_amp_on: assert property ($rose(amp_drive_enable) |-> ##[1:6] column_drive_en)
        else $error("column drive not on after amp rise");
    a_drive_hold: assert property (column_drive_en && amp_drive_enable && !line_latch_strobe |=> column_drive_en)
        else $error("column drive dropped while amp high");
    a_drive_cause: assert property ($rose(column_drive_en) |-> amp_drive_enable)
        else $error("column drive rose without amp");
    a_level_hold: assert property ($changed(column_level) |-> line_latch_strobe)
        else $error("column levels changed without strobe");
    a_common_pair: assert property ($changed(gamma_positive) |->
        line_latch_strobe && gamma_positive == polarity_select && common_drive_out != gamma_positive)
        else $error("polarity outputs wrong at strobe");
    a_gamma_follow: assert property ($stable(curve_source_select) [*6] |-> gamma_external == curve_source_select)
        else $error("gamma source does not follow pin");
    a_gate_blank: assert property (gate_output_enable_n [*6] |-> gate_out == '0)
        else $error("row outputs on while disabled");

    cover property ($rose(column_drive_en));
    cover property ($changed(column_level));
    cover property (gate_out != '0);
endmodule // tpdi_panel_chk

bind tpdi_panel tpdi_panel_chk #(.COLS(COLS), .ROWS(ROWS)) chk (.*);

// ==== tb/tpdi_ctrl_model.sv ====
module tpdi_ctrl_model #(
    parameter COLS = 4
) (
    input  wire logic pclk,
    output logic      column_shift_clock,
    output logic      line_latch_strobe,
    output logic      line_start_pulse,
    output logic      polarity_select,
    output logic      data_invert,
    output logic      amp_drive_enable,
    output logic      gate_shift_clock,
    output logic      frame_start_pulse,
    output logic [5:0] red_data,
    output logic [5:0] green_data,
    output logic [5:0] blue_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {column_shift_clock, line_latch_strobe, line_start_pulse, polarity_select} = 4'h0;
        {data_invert, amp_drive_enable, gate_shift_clock, frame_start_pulse} = 4'h0;
        {red_data, green_data, blue_data} = 18'h00000;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Each clock level lasts four cycles so that it outlasts the synchroniser.
    task automatic col_tick();
        column_shift_clock <= 1'b1;
        wt(4);
        column_shift_clock <= 1'b0;
        wt(4);
    endtask
    task automatic send_line(input logic [COLS*18-1:0] ln, input logic flip, input logic polar);
        data_invert <= flip;
        line_start_pulse <= 1'b1;
        col_tick();
        line_start_pulse <= 1'b0;
        for (int i = 0; i < COLS; i++)
        begin
            {red_data, green_data, blue_data} <= ln[i*18+:18];
            col_tick();
        end
        {red_data, green_data, blue_data} <= ~ln[COLS*18-18+:18];
        polarity_select <= polar;
        amp_drive_enable <= 1'b0;
        wt(1);
        line_latch_strobe <= 1'b1;
        column_shift_clock <= 1'b1;
        wt(4);
        column_shift_clock <= 1'b0;
        wt(2);
        line_latch_strobe <= 1'b0;
        wt(2);
        col_tick();
        col_tick();
    endtask
    task automatic amp_on();
        amp_drive_enable <= 1'b1;
        wt(8);
    endtask
    task automatic gate_step(input logic sp);
        frame_start_pulse <= sp;
        wt(4);
        gate_shift_clock <= 1'b1;
        wt(4);
        gate_shift_clock <= 1'b0;
        wt(8);
    endtask
endmodule // tpdi_ctrl_model

// ==== tb/test_tpdi_panel.sv ====
module test_tpdi_panel;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NC = 4;
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } tpdi_row_t;
    logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic             column_shift_clock, line_latch_strobe, line_start_pulse, polarity_select;
    logic             data_invert, amp_drive_enable, gate_shift_clock, gate_output_enable_n;
    logic             frame_start_pulse, curve_source_select, column_drive_en, common_drive_out;
    logic             gamma_positive, gamma_external;
    logic [5:0]       red_data, green_data, blue_data;
    logic [NC*18-1:0] column_level;
    logic [NC-1:0]    gate_out;
    int               miscompares = 0;
    int               n_checks = 0;
    tpdi_row_t        rows [6] = '{
        '{1'b0, 12'h000, 32'h0, 32'h4, 1'b0},
        '{1'b1, 12'h000, 32'h3, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'h3, 1'b0},
        '{1'b1, 12'h004, 32'hff, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}
    };

    tpdi_panel #(.COLS(NC), .ROWS(NC)) uut (.*);
    tpdi_ctrl_model #(.COLS(NC)) ctl (.*);

    always #50 pclk = ~pclk;

    task automatic wrap_up();
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            chk(pready, 1'b1);
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic line_case(input logic [NC*18-1:0] px, input logic flip, input logic polar, input int len);
        logic [NC*18-1:0] x;
        x = '0;
        for (int i = 0; i < len; i++)
            x[i*18+:18] = flip ? ~px[i*18+:18] : px[i*18+:18];
        apb(1'b1, 12'h000, len, rd, er);
        ctl.send_line(px, flip, polar);
        chk(column_level, x);
        chk(common_drive_out, !polar);
        chk(gamma_positive, polar);
        chk(column_drive_en, 1'b0);
        ctl.amp_on();
        chk(column_drive_en, 1'b1);
    endtask

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, curve_source_select} = 6'h00;
        {ce, gate_output_enable_n} = 2'h3;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
            chk(er, rows[i].e);
            if (!rows[i].wr)
                chk(rd, rows[i].q);
        end
        line_case({18'h3f000, 18'h00fc0, 18'h0003f, 18'h2a555}, 1'b0, 1'b1, NC);
        apb(1'b1, 12'h008, 32'h2, rd, er);
        apb(1'b0, 12'h00c, 32'h0, rd, er);
        chk(rd, 32'h00fc0);
        line_case({18'h12345, 18'h3ffff, 18'h00000, 18'h1c0e3}, 1'b1, 1'b0, 3);
        gate_output_enable_n <= 1'b0;
        ctl.gate_step(1'b1);
        chk(gate_out, 4'h1);
        ctl.gate_step(1'b0);
        chk(gate_out, 4'h2);
        gate_output_enable_n <= 1'b1;
        wt(8);
        chk(gate_out, 4'h0);
        gate_output_enable_n <= 1'b0;
        wt(8);
        chk(gate_out, 4'h2);
        curve_source_select <= 1'b1;
        wt(8);
        chk(gamma_external, 1'b1);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk(rd[13:9], 5'h16);
        ce <= 1'b0;
        apb(1'b1, 12'h000, 32'h5, rd, er);
        ce <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, rd, er);
        chk(rd, 32'h3);
        presetn <= 1'b0;
        wt(2);
        chk(column_level, 72'h0);
        chk({column_drive_en, common_drive_out, gamma_external, gate_out}, 7'h00);
        presetn <= 1'b1;
        wt(4);
        wrap_up();
    end
endmodule // test_tpdi_panel
